/* File: hw/lrc_pkg.sv */
package lrc_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
   localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_LOWER   = 8'h04;
   localparam logic [7:0]  OFS_UPPER   = 8'h08;
   localparam logic [7:0]  OFS_TIME_LO = 8'h0C;
   localparam logic [7:0]  OFS_TIME_UP = 8'h10;
   localparam logic [7:0]  OFS_PURGE   = 8'h14;
   localparam logic [7:0]  OFS_POST    = 8'h18;
   localparam logic [7:0]  OFS_PAUSE   = 8'h1C;
   localparam logic [7:0]  OFS_STATUS  = 8'h20;
   localparam int          POS_MODE    = 0;
   localparam int          POS_FUNC    = 2;
   localparam int          POS_CNT     = 6;
   localparam int          POS_UNATT   = 10;
   localparam int          POS_TRIG    = 11;
   localparam int          POS_SEC     = 0;
   localparam int          POS_MIN     = 8;
   localparam logic [31:0] RST_CTRL    = 32'h0000_0140;
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [31:0] RST_PAUSE   = 32'h0000_000A;
   localparam logic [6:0]  MMSS_MAX    = 7'h63;

   // ---------------------------------------------------------------
   // indicator estimate
   // ---------------------------------------------------------------
   localparam int unsigned HORIZON_H    = 72;
   localparam int unsigned HORIZON_S    = HORIZON_H * 3600;
   localparam logic [6:0]  FILL_MIN_PCT = 7'h0A;
   localparam int          AVG_DEPTH    = 10;
   localparam logic [15:0] DOSE_BASE_UL = 16'h005A;
   localparam int          DOSE_SHIFT   = 4;
   localparam logic [15:0] ANALYSIS_S   = 16'h0078;

   typedef enum logic [1:0] {LRC_MD_SINGLE = 2'h0, LRC_MD_TWO = 2'h1,
                             LRC_MD_RANGE = 2'h2} lrc_mode_t;
   typedef enum logic [1:0] {LRC_FN_DURATION = 2'h0, LRC_FN_IMPULSE = 2'h1,
                             LRC_FN_INTERVAL = 2'h2} lrc_func_t;
   typedef enum logic [1:0] {LRC_TR_TIME = 2'h0, LRC_TR_VOL = 2'h1,
                             LRC_TR_VOLTIME = 2'h2} lrc_trig_t;
   typedef enum logic [3:0] {LRC_ST_IDLE = 4'h1, LRC_ST_ON = 4'h2,
                             LRC_ST_OFF = 4'h4, LRC_ST_SPENT = 4'h8} lrc_rly_st_t;
   typedef enum logic [1:0] {LRC_PG_IDLE = 2'h1, LRC_PG_RUN = 2'h2} lrc_pg_st_t;

endpackage

/* File: hw/lrc_relay_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lrc_relay_if;
   logic        meas;
   logic        set_cond;
   logic        clr_cond;
   logic        tick;
   logic [1:0]  func;
   logic [1:0]  count;
   logic [12:0] time_s;
   logic        relay;
   logic        qualified;
   logic        repeat_req;
   modport ctrl (output meas, set_cond, clr_cond, tick, func, count, time_s,
                 input relay, qualified, repeat_req);
   modport chan (input meas, set_cond, clr_cond, tick, func, count, time_s,
                 output relay, qualified, repeat_req);
endinterface
`default_nettype wire

/* File: hw/lrc_relay.sv */
`timescale 1ns/1ps
`default_nettype none
module lrc_relay (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // channel
   lrc_relay_if.chan bus
);
   import lrc_pkg::*;

   lrc_rly_st_t st_q, st_d;
   logic [1:0]  cnt_q;
   logic [12:0] tmr_q;
   logic        qual_q, rpt_q, relay_q;

   wire       hit    = bus.meas & bus.set_cond & ~bus.clr_cond;
   wire       drop   = bus.meas & bus.clr_cond;
   wire [1:0] need   = (bus.count == 2'h0) ? 2'h1 : bus.count;
   wire       last   = (cnt_q + 2'h1) >= need;
   wire       expire = (tmr_q == 13'h0000) | (bus.tick & (tmr_q == 13'h0001));
   wire       is_imp = bus.func == LRC_FN_IMPULSE;
   wire       is_int = bus.func == LRC_FN_INTERVAL;
   wire       load   = (st_d != st_q) & ((st_d == LRC_ST_ON) | (st_d == LRC_ST_OFF));

   always_comb begin
      st_d = st_q;
      case (st_q)
         LRC_ST_IDLE:  if (qual_q) st_d = LRC_ST_ON;
         LRC_ST_ON:    if (is_imp & expire) st_d = LRC_ST_SPENT;
                       else if (!is_imp & !qual_q) st_d = LRC_ST_IDLE;
                       else if (is_int & expire) st_d = LRC_ST_OFF;
         LRC_ST_OFF:   if (!qual_q) st_d = LRC_ST_IDLE;
                       else if (expire) st_d = LRC_ST_ON;
         LRC_ST_SPENT: if (!qual_q) st_d = LRC_ST_IDLE;
         default:      st_d = LRC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q    <= LRC_ST_IDLE;
         tmr_q   <= 13'h0000;
         relay_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         relay_q <= st_d == LRC_ST_ON;
         if (load) tmr_q <= bus.time_s;
         else if (bus.tick & (tmr_q != 13'h0000)) tmr_q <= tmr_q - 13'h0001;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q  <= 2'h0;
         qual_q <= 1'b0;
         rpt_q  <= 1'b0;
      end else begin
         rpt_q <= hit & ~last & ~qual_q;
         if (drop) begin
            cnt_q  <= 2'h0;
            qual_q <= 1'b0;
         end else if (hit & last) begin
            qual_q <= 1'b1;
         end else if (hit & ~qual_q) begin
            cnt_q  <= cnt_q + 2'h1;
         end
      end
   end

   assign bus.relay      = relay_q;
   assign bus.qualified  = qual_q;
   assign bus.repeat_req = rpt_q;

   a_repeat_first: assert property (@(posedge clk) disable iff (sys_rst)
      hit & (need == 2'h2) & (cnt_q == 2'h0) & !qual_q |=> rpt_q & !qual_q)
      else $error("first exceedance with count two did not request a repeat");
endmodule
`default_nettype wire

/* File: hw/lrc_top.sv */
// Overview of operation
// - single mode: each relay switches when measurement exceeds its limit
// - two-point: upper relay on above upper, off below lower, else holds
// - two-point: lower relay acts as plain limit relay on lower value
// - range: lower relay below lower limit, upper relay above upper
// - each relay has its own switching function, mode is shared
// - relay time runs from 00:00 to 99 min 99 s
// - each relay counts one, two or three exceedances before switching
// - count defaults to one: switch on first exceedance, no delay
// - count two: first exceedance requests immediate repeat analysis
// - count three needs three in a row, re-arms below limit
// - duration: relay follows exceedance, drops on first good value
// - impulse: relay on for the set time, counted in seconds ticks, so up to one second short
// - no new impulse until a value falls below the limit
// - purge opens inlet and outlet valves for purge seconds, default zero
// - analysis interval always holds the whole purge time; the estimate period adds purge seconds only, not the post-exceed time
// - next purge after exceedance lengthened by post-exceed time
// - unattended mode estimates indicator cover for next 72 hours
// - shortage in unattended mode: low alarm, flashing symbol, alarm relay
// - unattended off: shortage only below ten percent fill
// - unattended mode refused unless trigger is purely time based
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lrc_top #(
   parameter int unsigned TICK_CYCLES = lrc_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // measurement engine
   input  wire logic        meas_valid,
   input  wire logic [15:0] meas_value,
   input  wire logic        analysis_start,
   input  wire logic [15:0] fill_level_ul,
   input  wire logic [6:0]  fill_pct,
   output logic             purge_done,
   output logic             repeat_analysis,
   // process outputs
   output logic             lower_limit_relay,
   output logic             upper_limit_relay,
   output logic             inlet_valve,
   output logic             outlet_valve,
   output logic             alarm_relay,
   output logic             indicator_low,
   output logic             unattended_symbol
);
   import lrc_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = a == o;
   endfunction

   function automatic logic [6:0] lim99(input logic [6:0] v);
      lim99 = (v > MMSS_MAX) ? MMSS_MAX : v;
   endfunction

   function automatic logic [12:0] to_secs(input logic [31:0] r);
      to_secs = 13'(r[POS_MIN +: 7]) * 13'h003C + 13'(r[POS_SEC +: 7]);
   endfunction

   function automatic logic [31:0] mmss(input logic [31:0] w);
      mmss = RST_ZERO;
      mmss[POS_MIN +: 7] = lim99(w[POS_MIN +: 7]);
      mmss[POS_SEC +: 7] = lim99(w[POS_SEC +: 7]);
   endfunction

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   logic [31:0] ctrl_q, lower_q, upper_q, tlo_q, tup_q;
   logic [31:0] purge_q, post_q, pause_q, rdata_q;
   logic        wait_q;
   logic [31:0] rd_mux, status;

   // one wait state: waitrequest drops for the single cycle that completes
   wire wr_en = avs_write & ~wait_q;
   wire rd_go = avs_read & wait_q;

   assign rd_mux =
      hit(avs_address, OFS_CTRL)    ? ctrl_q  :
      hit(avs_address, OFS_LOWER)   ? lower_q :
      hit(avs_address, OFS_UPPER)   ? upper_q :
      hit(avs_address, OFS_TIME_LO) ? tlo_q   :
      hit(avs_address, OFS_TIME_UP) ? tup_q   :
      hit(avs_address, OFS_PURGE)   ? purge_q :
      hit(avs_address, OFS_POST)    ? post_q  :
      hit(avs_address, OFS_PAUSE)   ? pause_q :
      hit(avs_address, OFS_STATUS)  ? status  : RST_ZERO;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_q  <= 1'b1;
         rdata_q <= RST_ZERO;
      end else begin
         wait_q <= ~((avs_read | avs_write) & wait_q);
         if (rd_go) rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q  <= RST_CTRL;
         lower_q <= RST_ZERO;
         upper_q <= RST_ZERO;
         tlo_q   <= RST_ZERO;
         tup_q   <= RST_ZERO;
         purge_q <= RST_ZERO;
         post_q  <= RST_ZERO;
         pause_q <= RST_PAUSE;
      end else if (wr_en) begin
         if (hit(avs_address, OFS_CTRL)) ctrl_q <= {19'h00000, avs_writedata[12:0]};
         if (hit(avs_address, OFS_LOWER)) lower_q <= {16'h0000, avs_writedata[15:0]};
         if (hit(avs_address, OFS_UPPER)) upper_q <= {16'h0000, avs_writedata[15:0]};
         if (hit(avs_address, OFS_TIME_LO)) tlo_q <= mmss(avs_writedata);
         if (hit(avs_address, OFS_TIME_UP)) tup_q <= mmss(avs_writedata);
         if (hit(avs_address, OFS_POST)) post_q <= mmss(avs_writedata);
         if (hit(avs_address, OFS_PURGE)) purge_q <= {24'h000000, avs_writedata[7:0]};
         if (hit(avs_address, OFS_PAUSE)) pause_q <= {25'h0000000, lim99(avs_writedata[6:0])};
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;

   // ---------------------------------------------------------------
   // seconds tick
   // ---------------------------------------------------------------
   logic [24:0] tick_cnt_q;
   logic        tick_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_q <= 25'h0000000;
         tick_q     <= 1'b0;
      end else begin
         tick_q <= tick_cnt_q == 25'(TICK_CYCLES - 1);
         if (tick_cnt_q == 25'(TICK_CYCLES - 1)) tick_cnt_q <= 25'h0000000;
         else tick_cnt_q <= tick_cnt_q + 25'h0000001;
      end
   end

   // ---------------------------------------------------------------
   // limit comparison per mode
   // ---------------------------------------------------------------
   wire [1:0]  mode   = ctrl_q[POS_MODE +: 2];
   wire        md_two = mode == LRC_MD_TWO;
   wire        md_rng = mode == LRC_MD_RANGE;
   wire        gt_lo  = meas_value > lower_q[15:0];
   wire        lt_lo  = meas_value < lower_q[15:0];
   wire        gt_up  = meas_value > upper_q[15:0];
   logic [1:0] set_c, clr_c;

   assign set_c[0] = md_rng ? lt_lo : gt_lo;
   assign clr_c[0] = ~set_c[0];
   assign set_c[1] = gt_up;
   assign clr_c[1] = md_two ? lt_lo : ~gt_up;

   // ---------------------------------------------------------------
   // relay channels
   // ---------------------------------------------------------------
   lrc_relay_if rif[2] ();
   logic [1:0]  qual, relay, rpt;
   logic [12:0] tsec [2];

   assign tsec[0] = to_secs(tlo_q);
   assign tsec[1] = to_secs(tup_q);

   generate
      for (genvar i = 0; i < 2; i++) begin : g_ch
         assign rif[i].meas     = meas_valid;
         assign rif[i].set_cond = set_c[i];
         assign rif[i].clr_cond = clr_c[i];
         assign rif[i].tick     = tick_q;
         assign rif[i].func     = ctrl_q[POS_FUNC + 2*i +: 2];
         assign rif[i].count    = ctrl_q[POS_CNT + 2*i +: 2];
         assign rif[i].time_s   = tsec[i];
         assign qual[i]         = rif[i].qualified;
         assign relay[i]        = rif[i].relay;
         assign rpt[i]          = rif[i].repeat_req;
         lrc_relay u_relay (
            .clk     (clk),
            .sys_rst (sys_rst),
            .bus     (rif[i])
         );
      end
   endgenerate

   assign lower_limit_relay = relay[0];
   assign upper_limit_relay = relay[1];

   // ---------------------------------------------------------------
   // measurement history for the indicator estimate
   // ---------------------------------------------------------------
   // the average reads low until ten values have been seen
   logic [15:0] hist_q [AVG_DEPTH];
   logic [3:0]  hptr_q;
   logic [19:0] sum_q;

   wire [19:0] avg20 = sum_q / 20'(AVG_DEPTH);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hptr_q <= 4'h0;
         sum_q  <= 20'h00000;
         for (int k = 0; k < AVG_DEPTH; k++) hist_q[k] <= 16'h0000;
      end else if (meas_valid) begin
         sum_q          <= sum_q + 20'(meas_value) - 20'(hist_q[hptr_q]);
         hist_q[hptr_q] <= meas_value;
         hptr_q         <= (hptr_q == 4'(AVG_DEPTH - 1)) ? 4'h0 : hptr_q + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // purge sequence
   // ---------------------------------------------------------------
   lrc_pg_st_t  pg_q, pg_d;
   logic [13:0] pg_tmr_q;
   logic        post_pend_q, valve_q, done_q, rpt_q;

   wire        exceed_evt = meas_valid & |(set_c & ~clr_c);
   wire [13:0] pg_len = 14'(purge_q[7:0]) + (post_pend_q ? 14'(to_secs(post_q)) : 14'h0000);
   wire        pg_end = (pg_tmr_q == 14'h0000) | (tick_q & (pg_tmr_q == 14'h0001));

   always_comb begin
      pg_d = pg_q;
      case (pg_q)
         LRC_PG_IDLE: if (analysis_start) pg_d = LRC_PG_RUN;
         LRC_PG_RUN:  if (pg_end) pg_d = LRC_PG_IDLE;
         default:     pg_d = LRC_PG_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pg_q     <= LRC_PG_IDLE;
         pg_tmr_q <= 14'h0000;
         valve_q  <= 1'b0;
         done_q   <= 1'b0;
      end else begin
         pg_q    <= pg_d;
         valve_q <= pg_d == LRC_PG_RUN;
         done_q  <= (pg_q == LRC_PG_RUN) & pg_end;
         if ((pg_q == LRC_PG_IDLE) & analysis_start) pg_tmr_q <= pg_len;
         else if (tick_q & (pg_tmr_q != 14'h0000)) pg_tmr_q <= pg_tmr_q - 14'h0001;
      end
   end

   // extend next purge
   // a new exceedance in the start cycle wins over the clear
   wire pg_take = (pg_q == LRC_PG_IDLE) & analysis_start;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         post_pend_q <= 1'b0;
         rpt_q       <= 1'b0;
      end else begin
         post_pend_q <= exceed_evt | (post_pend_q & ~pg_take);
         rpt_q       <= |rpt;
      end
   end

   assign inlet_valve     = valve_q;
   assign outlet_valve    = valve_q;
   assign purge_done      = done_q;
   assign repeat_analysis = rpt_q;

   // ---------------------------------------------------------------
   // indicator supervision
   // ---------------------------------------------------------------
   logic ind_low, alarm_q, sym_q;

   wire unatt_req    = ctrl_q[POS_UNATT];
   wire time_trig    = ctrl_q[POS_TRIG +: 2] == LRC_TR_TIME;
   wire unatt_on     = unatt_req & time_trig;
   wire unatt_refuse = unatt_req & ~time_trig;

   lrc_indicator u_ind (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .unattended_on (unatt_on),
      .fill_level_ul (fill_level_ul),
      .fill_pct      (fill_pct),
      .avg_value     (avg20[15:0]),
      .purge_s       (purge_q[7:0]),
      .pause_min     (pause_q[6:0]),
      .low           (ind_low)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         alarm_q <= 1'b0;
         sym_q   <= 1'b0;
      end else begin
         alarm_q <= unatt_on & ind_low;
         if (!unatt_on) sym_q <= 1'b0;
         else if (!ind_low) sym_q <= 1'b1;
         else if (tick_q) sym_q <= ~sym_q;
      end
   end

   assign alarm_relay       = alarm_q;
   assign indicator_low     = ind_low;
   assign unattended_symbol = sym_q;

   assign status = {23'h000000, post_pend_q, valve_q, unatt_refuse, unatt_on,
                    ind_low, qual[1], qual[0], relay[1], relay[0]};

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_single_upper: assert property (
      meas_valid & (mode == LRC_MD_SINGLE) & gt_up & (ctrl_q[POS_CNT+2 +: 2] == 2'h1)
      |=> qual[1])
      else $error("single mode did not qualify the upper relay");

   a_two_off: assert property (
      meas_valid & md_two & lt_lo |=> !qual[1])
      else $error("two-point upper relay not released below lower limit");

   a_two_hold: assert property (
      meas_valid & md_two & !lt_lo & !gt_up |=> $stable(qual[1]))
      else $error("two-point upper relay changed between limits");

   a_range_lower: assert property (
      meas_valid & md_rng & lt_lo & (ctrl_q[POS_CNT +: 2] == 2'h1) |=> qual[0])
      else $error("range mode did not qualify below the lower limit");

   a_dur_follow: assert property (
      $rose(qual[0]) & (ctrl_q[POS_FUNC +: 2] == LRC_FN_DURATION)
      |=> lower_limit_relay)
      else $error("duration relay did not follow the exceedance");

   a_valves_pair: assert property (
      (pg_q == LRC_PG_RUN) |-> ##1 (inlet_valve & outlet_valve) or ##1 purge_done)
      else $error("valves not open together during purge");

   a_post_extend: assert property (
      exceed_evt |=> post_pend_q)
      else $error("exceedance did not arm the purge extension");

   a_unatt_refused: assert property (
      !time_trig |=> !alarm_relay & !unattended_symbol)
      else $error("unattended mode active on a volume trigger");

   a_low_fill: assert property (
      !unatt_on & (fill_pct < FILL_MIN_PCT) |=> indicator_low)
      else $error("fill below minimum not flagged");

   a_alarm_low: assert property (
      unatt_on & indicator_low |=> alarm_relay)
      else $error("indicator shortage did not switch the alarm relay");
endmodule
`default_nettype wire

/* File: hw/lrc_indicator.sv */
`timescale 1ns/1ps
`default_nettype none
module lrc_indicator (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // estimate inputs
   input  wire logic        unattended_on,
   input  wire logic [15:0] fill_level_ul,
   input  wire logic [6:0]  fill_pct,
   input  wire logic [15:0] avg_value,
   input  wire logic [7:0]  purge_s,
   input  wire logic [6:0]  pause_min,
   // result
   output logic             low
);
   import lrc_pkg::*;

   logic low_q;

   // dose grows with hardness since titration runs longer on high readings
   wire [15:0] dose   = DOSE_BASE_UL + (avg_value >> DOSE_SHIFT);
   wire [15:0] period = 16'(purge_s) + 16'(pause_min) * 16'h003C + ANALYSIS_S;
   wire [39:0] have   = 40'(fill_level_ul) * 40'(period);
   wire [39:0] need   = 40'(dose) * 40'(HORIZON_S);
   wire        short  = have < need;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) low_q <= 1'b0;
      else low_q <= (fill_pct < FILL_MIN_PCT) | (unattended_on & short);
   end

   assign low = low_q;
endmodule
`default_nettype wire

/* File: tb/lrc_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lrc_engine_model (
   // clock
   input  wire logic   clk,
   // block handshake
   input  wire logic   purge_done,
   output logic        analysis_start,
   output logic        meas_valid,
   output logic [15:0] meas_value
);
   initial begin
      analysis_start = 1'b0;
      meas_valid = 1'b0;
      meas_value = 16'hFFFF;
   end
   task automatic run(input logic [15:0] v, output bit ok);
      ok = 1'b0;
      @(posedge clk) analysis_start <= 1'b1;
      @(posedge clk) analysis_start <= 1'b0;
      for (int n = 0; n < 400 && !ok; n++) @(posedge clk) ok = (purge_done === 1'b1);
      meas_valid <= 1'b1;
      meas_value <= v;
      // value is stale outside the pulse, so show its inverse
      @(posedge clk) meas_valid <= 1'b0;
      meas_value <= ~v;
   endtask
endmodule
`default_nettype wire

/* File: tb/limit_relay_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module limit_relay_controller_tb;
   import lrc_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
   logic        avs_waitrequest, analysis_start, meas_valid, purge_done;
   logic        repeat_analysis, lower_limit_relay, upper_limit_relay, ind_low, alarm;
   logic [6:0]  pct = 7'h64;
   logic [15:0] meas_value, lim, v, seed = 16'hD960;
   int          n_mismatch = 0, n_compared = 0, cyc = 0;
   bit          ok;
   always #25 clk = ~clk;
   lrc_top #(.TICK_CYCLES(20)) u_dut (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid),
      .meas_value(meas_value), .analysis_start(analysis_start),
      .fill_level_ul(16'hFFFF), .fill_pct(pct), .purge_done(purge_done),
      .repeat_analysis(repeat_analysis), .lower_limit_relay(lower_limit_relay),
      .upper_limit_relay(upper_limit_relay), .inlet_valve(), .outlet_valve(),
      .alarm_relay(alarm), .indicator_low(ind_low), .unattended_symbol());
   lrc_engine_model u_eng (.clk(clk), .purge_done(purge_done),
      .analysis_start(analysis_start), .meas_valid(meas_valid), .meas_value(meas_value));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // relay and one-cycle repeat pulse stand one cycle after meas_valid is taken
   task automatic meas(input logic [15:0] x);
      u_eng.run(x, ok);
      chk("purge_done", 32'(ok), 32'h1);
      repeat (1) @(posedge clk);
      #1;
   endtask
   task automatic results;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", rd_q, RST_CTRL);
      bus(1'b0, 8'h24, 32'h0);
      chk("unmapped", rd_q, 32'h0);
      seed = nx(seed);
      lim = (seed & 16'h7FFF) | 16'h0001;
      bus(1'b1, OFS_LOWER, {16'h0, lim});
      // short purge is only a recommendation, kept short for run time
      bus(1'b1, OFS_PURGE, 32'h2);
      // equal value is not an exceedance
      for (int i = 0; i < 8; i++) begin
         seed = nx(seed);
         v = (i == 0) ? lim : (i == 1) ? lim + 16'h1 : seed;
         meas(v);
         chk("lower_relay", 32'(lower_limit_relay), 32'(v > lim));
      end
      bus(1'b1, OFS_CTRL, 32'h180);
      meas(16'h0000);
      meas(lim + 16'h1);
      chk("repeat", 32'(repeat_analysis), 32'h1);
      chk("lower_relay", 32'(lower_limit_relay), 32'h0);
      meas(lim + 16'h1);
      chk("lower_relay", 32'(lower_limit_relay), 32'h1);
      bus(1'b1, OFS_UPPER, {16'h0, lim});
      bus(1'b1, OFS_CTRL, 32'h142);
      meas(16'h0000);
      chk("lower_relay", 32'(lower_limit_relay), 32'h1);
      chk("upper_relay", 32'(upper_limit_relay), 32'h0);
      meas(lim + 16'h1);
      chk("lower_relay", 32'(lower_limit_relay), 32'h0);
      chk("upper_relay", 32'(upper_limit_relay), 32'h1);
      @(posedge clk) pct <= 7'h05;
      repeat (2) @(posedge clk);
      #1;
      chk("indicator_low", 32'(ind_low), 32'h1);
      chk("alarm", 32'(alarm), 32'h0);
      results();
   end
endmodule
`default_nettype wire
